// File: logic/lbl_com_pins.sv
// Purpose: common line decode and pin direction override
// Assumes: pinDir bit 1 means input, as for a plain i/o pin
// Notes: outputs are registered
`timescale 1ns/10ps
module lbl_com_pins (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstSyncB,
    // configuration
    input wire logic [1:0] muxSel,
    input wire logic [3:0] pinDir,
    // pin control
    output logic [3:0] comActive,
    output logic [3:0] pinOe
);
    import lbl_pkg::*;

    typedef struct packed {
        logic [3:0] comActive;
        logic [3:0] pinOe;
    } lbl_com_state_t;

    lbl_com_state_t st;
    lbl_com_state_t next_st;
    logic [3:0] useAsCom;

    // ****************************************
    // per pin decode
    // ****************************************
    for (genvar i = 0; i < 4; i++) begin : g_pin
        assign useAsCom[i] = (2'(i) <= muxSel);
    end

    always_comb begin
        next_st.comActive = useAsCom;
        // common driver ignores direction bit
        next_st.pinOe = useAsCom | ~pinDir;
    end

    always_ff @(posedge clk_sys or negedge rstSyncB) begin
        if (!rstSyncB) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign comActive = st.comActive;
    assign pinOe = st.pinOe;
endmodule // lbl_com_pins

// File: logic/lbl_ladder.sv
// Purpose: lcd bias reference ladder, contrast and reference control
// Assumes: lcdTick is a one-cycle pulse per 32 khz source clock
// Notes: registers reached over apb, zero wait states
//
// Overview of operation
// - half bias select shorts the middle ladder resistor
// - ladder has off, low, medium and high power settings
// - inactive module forces the reference ladder off
// - A setting after each transition and each prescaler wrap, then B until the period ends
// - A/B switching timed by the 5-bit 32 khz prescaler
// - bits 7-6 give ladder power during interval A
// - bits 5-4 give ladder power during interval B, same encoding
// - bits 2-0 give A length in clocks; zero means always B
// - waveform type 0: n clocks A then 16 minus n clocks B
// - waveform type 1: n clocks A then 32 minus n clocks B
// - 3-bit contrast setting selects one of eight ladder taps
// - inactive module switches the contrast ladder off
// - no internal reference disables contrast control
// - inactive module turns the internal bias reference off
// - fixed ref, idle bit and interval B disable the ref buffer
// - fixed voltage reference requested automatically when needed
// - three bias pins each have independent connect control
// - multiplex setting decodes to the active common lines
// - active common pins override the direction bit
// - bias pin enable connects the pin to its bias node
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module lbl_ladder (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire lbl_pkg::lbl_apb_req_t apbReq,
    output lbl_pkg::lbl_apb_rsp_t apbRsp,
    // lcd controller timing
    input wire logic lcdTick,
    input wire logic lcdTransition,
    input wire logic moduleActive,
    // analog and pin control
    output lbl_pkg::lbl_bias_out_t biasOut,
    output logic [3:0] comActive,
    output logic [3:0] pinOe
);
    import lbl_pkg::*;

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rstShift;
    logic rstSyncB;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rstShift <= 2'b00;
        end else begin
            rstShift <= {rstShift[0], 1'b1};
        end
    end

    assign rstSyncB = rstShift[1];

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0] ladderCtrl;
        logic [3:0] dispCtrl;
        logic [7:0] refCtrl;
        logic [2:0] contrast;
        logic [3:0] pinDir;
        logic [4:0] prescaler;
        lbl_phase_t phase;
        lbl_apb_rsp_t rsp;
        lbl_bias_out_t out;
    } lbl_state_t;

    lbl_state_t st;
    lbl_state_t next_st;

    // ****************************************
    // field views
    // ****************************************
    logic [1:0] aPower;
    logic [1:0] bPower;
    logic [2:0] aLength;
    logic [1:0] muxSel;
    logic waveType;
    logic halfBias;
    logic refOn;
    logic refFixed;
    logic refIdle;
    logic [2:0] pinEnable;

    assign aPower = st.ladderCtrl[LBL_LAD_APWR_LSB +: 2];
    assign bPower = st.ladderCtrl[LBL_LAD_BPWR_LSB +: 2];
    assign aLength = st.ladderCtrl[LBL_LAD_LEN_LSB +: 3];
    assign muxSel = st.dispCtrl[LBL_DSP_MUX_LSB +: 2];
    assign waveType = st.dispCtrl[LBL_DSP_WFT_BIT];
    assign halfBias = st.dispCtrl[LBL_DSP_HALF_BIT];
    assign refOn = st.refCtrl[LBL_REF_EN_BIT];
    assign refFixed = st.refCtrl[LBL_REF_FIXED_BIT];
    assign refIdle = st.refCtrl[LBL_REF_IDLE_BIT];
    assign pinEnable = st.refCtrl[LBL_REF_PIN_LSB +: 3];

    // ****************************************
    // bus decode
    // ****************************************
    logic setupPhase;
    logic writeTaken;
    logic addrHit;
    logic [31:0] readWord;

    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign writeTaken = apbReq.psel && apbReq.penable
        && st.rsp.pready && apbReq.pwrite;

    always_comb begin
        addrHit = 1'b1;
        readWord = 32'h0000_0000;
        unique case (apbReq.paddr)
            LBL_OFS_LADDER: begin
                readWord[7:0] = st.ladderCtrl;
            end
            LBL_OFS_DISPLAY: begin
                readWord[3:0] = st.dispCtrl;
                readWord[LBL_DSP_ACT_BIT] = moduleActive;
            end
            LBL_OFS_BIASREF: begin
                readWord[7:0] = st.refCtrl;
            end
            LBL_OFS_CONTRAST: begin
                readWord[2:0] = st.contrast;
            end
            LBL_OFS_PINDIR: begin
                readWord[3:0] = st.pinDir;
            end
            LBL_OFS_STATUS: begin
                readWord[1:0] = st.phase;
                readWord[3:2] = st.out.ladderPower;
                readWord[7:4] = comActive;
                readWord[11:8] = pinOe;
                readWord[12] = st.out.fvrBufferEnable;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // interval timing
    // ****************************************
    logic [4:0] period;
    logic [4:0] next_pre;
    logic inA;

    // switching period length by waveform type
    assign period = waveType ? LBL_PERIOD_WFT1 : LBL_PERIOD_WFT0;

    always_comb begin
        next_pre = st.prescaler;
        if (!moduleActive) begin
            next_pre = 5'h00;
        end else if (lcdTransition) begin
            // restart so each period opens in A
            next_pre = 5'h00;
        end else if (lcdTick) begin
            if (st.prescaler >= period) begin
                next_pre = 5'h00;
            end else begin
                next_pre = st.prescaler + 5'h01;
            end
        end
    end

    // zero length never enters A
    assign inA = (aLength != 3'h0)
        && (next_pre < {2'b00, aLength});

    // ****************************************
    // next state
    // ****************************************
    logic [1:0] powerSel;
    logic refLive;

    always_comb begin
        next_st = st;
        next_st.prescaler = next_pre;

        // registers
        if (writeTaken) begin
            unique case (apbReq.paddr)
                LBL_OFS_LADDER: begin
                    next_st.ladderCtrl = apbReq.pwdata[7:0]
                        & LBL_MSK_LADDER;
                end
                LBL_OFS_DISPLAY: begin
                    next_st.dispCtrl = apbReq.pwdata[3:0];
                end
                LBL_OFS_BIASREF: begin
                    next_st.refCtrl = apbReq.pwdata[7:0]
                        & LBL_MSK_BIASREF;
                end
                LBL_OFS_CONTRAST: begin
                    next_st.contrast = apbReq.pwdata[2:0];
                end
                LBL_OFS_PINDIR: begin
                    next_st.pinDir = apbReq.pwdata[3:0];
                end
                default: begin
                end
            endcase
        end

        // bus answer, one access cycle after setup
        next_st.rsp.pready = setupPhase;
        next_st.rsp.pslverr = setupPhase && !addrHit;
        next_st.rsp.prdata = (setupPhase && !apbReq.pwrite)
            ? readWord : 32'h0000_0000;

        // interval phase
        if (!moduleActive) begin
            next_st.phase = LBL_OFF;
        end else if (inA) begin
            next_st.phase = LBL_PHASE_A;
        end else begin
            next_st.phase = LBL_PHASE_B;
        end

        // ladder power per phase
        unique case (next_st.phase)
            LBL_PHASE_A: powerSel = aPower;
            LBL_PHASE_B: powerSel = bPower;
            default: powerSel = LBL_PWR_OFF;
        endcase
        next_st.out.ladderPower = powerSel;
        // off disconnects every section
        next_st.out.ladderConnect = (powerSel != LBL_PWR_OFF);
        next_st.out.shortMiddle = halfBias
            && (powerSel != LBL_PWR_OFF);
        next_st.out.inIntervalA = (next_st.phase == LBL_PHASE_A);

        // reference and contrast
        refLive = refOn && moduleActive;
        next_st.out.refEnable = refLive;
        next_st.out.contrastTap = st.contrast;
        next_st.out.contrastEnable = refLive;
        next_st.out.fvrRequest = refLive && refFixed;
        next_st.out.fvrBufferEnable = refLive && refFixed
            && !(refIdle && next_st.phase == LBL_PHASE_B);

        // external bias pins, each on its own
        next_st.out.biasPinConnect = pinEnable;
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge rstSyncB) begin
        if (!rstSyncB) begin
            st.ladderCtrl <= LBL_RST_LADDER;
            st.dispCtrl <= LBL_RST_DISPLAY;
            st.refCtrl <= LBL_RST_BIASREF;
            st.contrast <= LBL_RST_CONTRAST;
            st.pinDir <= LBL_RST_PINDIR;
            st.prescaler <= 5'h00;
            st.phase <= LBL_OFF;
            st.rsp <= '0;
            st.out <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // common lines and pin direction
    // ****************************************
    lbl_com_pins u_com_pins (
        .clk_sys(clk_sys),
        .rstSyncB(rstSyncB),
        .muxSel(muxSel),
        .pinDir(st.pinDir),
        .comActive(comActive),
        .pinOe(pinOe)
    );

    assign apbRsp = st.rsp;
    assign biasOut = st.out;
endmodule // lbl_ladder

// File: logic/lbl_pkg.sv
// Purpose: shared constants and types for the lcd bias ladder control
// Assumes: 32-bit apb, one aligned word per register
// Notes: register offsets are byte addresses
package lbl_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] LBL_OFS_LADDER = 8'h00;
    localparam logic [7:0] LBL_OFS_DISPLAY = 8'h04;
    localparam logic [7:0] LBL_OFS_BIASREF = 8'h08;
    localparam logic [7:0] LBL_OFS_CONTRAST = 8'h0C;
    localparam logic [7:0] LBL_OFS_PINDIR = 8'h10;
    localparam logic [7:0] LBL_OFS_STATUS = 8'h14;

    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [7:0] LBL_RST_LADDER = 8'h00;
    localparam logic [7:0] LBL_MSK_LADDER = 8'hF7;
    localparam logic [3:0] LBL_RST_DISPLAY = 4'h0;
    localparam logic [7:0] LBL_RST_BIASREF = 8'h00;
    localparam logic [7:0] LBL_MSK_BIASREF = 8'hEE;
    localparam logic [2:0] LBL_RST_CONTRAST = 3'h0;
    localparam logic [3:0] LBL_RST_PINDIR = 4'hF;

    // ****************************************
    // field positions
    // ****************************************
    localparam int LBL_LAD_APWR_LSB = 6;
    localparam int LBL_LAD_BPWR_LSB = 4;
    localparam int LBL_LAD_LEN_LSB = 0;
    localparam int LBL_DSP_MUX_LSB = 0;
    localparam int LBL_DSP_WFT_BIT = 2;
    localparam int LBL_DSP_HALF_BIT = 3;
    localparam int LBL_DSP_ACT_BIT = 7;
    localparam int LBL_REF_EN_BIT = 7;
    localparam int LBL_REF_FIXED_BIT = 6;
    localparam int LBL_REF_IDLE_BIT = 5;
    localparam int LBL_REF_PIN_LSB = 1;

    // ****************************************
    // prescaler counts, in 32 khz source clocks
    // ****************************************
    localparam int LBL_PRE_W = 5;
    localparam logic [4:0] LBL_PERIOD_WFT0 = 5'h0F;
    localparam logic [4:0] LBL_PERIOD_WFT1 = 5'h1F;
    localparam logic [1:0] LBL_PWR_OFF = 2'h0;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        LBL_OFF = 2'b00,
        LBL_PHASE_A = 2'b01,
        LBL_PHASE_B = 2'b11
    } lbl_phase_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } lbl_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } lbl_apb_rsp_t;

    typedef struct packed {
        logic [1:0] ladderPower;
        logic ladderConnect;
        logic shortMiddle;
        logic inIntervalA;
        logic [2:0] contrastTap;
        logic contrastEnable;
        logic refEnable;
        logic fvrRequest;
        logic fvrBufferEnable;
        logic [2:0] biasPinConnect;
    } lbl_bias_out_t;

endpackage

// File: tb/lbl_ladder_monitor.sv
// Purpose: port-level checks on lbl_ladder
// Assumes: outputs registered, one edge behind their inputs
// Notes: bound to every lbl_ladder instance
`timescale 1ns/10ps
module lbl_ladder_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // register bus
    input wire lbl_pkg::lbl_apb_req_t apbReq,
    input wire lbl_pkg::lbl_apb_rsp_t apbRsp,
    // lcd state and pins
    input wire logic moduleActive,
    input wire lbl_pkg::lbl_bias_out_t biasOut,
    input wire logic [3:0] comActive,
    input wire logic [3:0] pinOe
);
    import lbl_pkg::*;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ****************************************
    // checks
    // ****************************************
    AST_READY_AFTER_SETUP: assert property (apbReq.psel && !apbReq.penable
        |=> apbRsp.pready) else $error("no ready after setup");
    AST_READY_ONE_CYCLE: assert property (apbRsp.pready |=> !apbRsp.pready)
        else $error("ready stood too long");
    AST_ERR_WITH_READY: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("error without ready");
    AST_INACTIVE_LADDER: assert property (!moduleActive [*2] |->
        biasOut.ladderPower == LBL_PWR_OFF && !biasOut.inIntervalA)
        else $error("ladder on while inactive");
    AST_INACTIVE_CONTRAST: assert property (!moduleActive
        |=> !biasOut.contrastEnable) else $error("contrast on while inactive");
    AST_INACTIVE_REF: assert property (!moduleActive
        |=> !biasOut.refEnable) else $error("reference on while inactive");
    AST_CONTRAST_NEEDS_REF: assert property (biasOut.contrastEnable
        |-> biasOut.refEnable) else $error("contrast without reference");
    AST_CONNECT_POWER: assert property (biasOut.ladderConnect ==
        (biasOut.ladderPower != LBL_PWR_OFF)) else $error("connect mismatch");
    AST_SHORT_NEEDS_LADDER: assert property (biasOut.shortMiddle
        |-> biasOut.ladderConnect) else $error("short on dead ladder");
    AST_FVR_AUTO: assert property (biasOut.fvrRequest
        |-> biasOut.refEnable) else $error("fvr request without reference");
    AST_FVR_BUFFER: assert property (biasOut.fvrBufferEnable
        |-> biasOut.fvrRequest) else $error("buffer on without request");
    AST_COM_OVERRIDE: assert property ((comActive & ~pinOe) == 4'h0)
        else $error("active common not driven");
    AST_COM_SHAPE: assert property (comActive != 4'h0 |->
        comActive inside {4'h1, 4'h3, 4'h7, 4'hF}) else $error("bad commons");
endmodule // lbl_ladder_monitor

bind lbl_ladder lbl_ladder_monitor i_mon (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .moduleActive(moduleActive),
    .biasOut(biasOut),
    .comActive(comActive),
    .pinOe(pinOe)
);

// File: tb/lbl_ladder_tb.sv
// Purpose: self-checking bench for lbl_ladder
// Assumes: zero wait state apb slave, tick model on lcdTick
// Notes: expectations built from field encodings only
`timescale 1ns/10ps
module lbl_ladder_tb;
    import lbl_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    lbl_apb_req_t apbReq = '0;
    lbl_apb_rsp_t apbRsp;
    logic lcdTick;
    logic lcdTransition = 1'b0;
    logic moduleActive = 1'b0;
    logic tickRun = 1'b0;
    lbl_bias_out_t biasOut;
    logic [3:0] comActive;
    logic [3:0] pinOe;
    int errors = 0;
    int checks = 0;

    always #4 clk_sys = ~clk_sys;

    lbl_ladder i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .apbReq(apbReq),
        .apbRsp(apbRsp), .lcdTick(lcdTick), .lcdTransition(lcdTransition),
        .moduleActive(moduleActive), .biasOut(biasOut),
        .comActive(comActive), .pinOe(pinOe));
    lbl_lcd_tick_model i_tick (.clk_sys(clk_sys), .run(tickRun),
        .lcdTick(lcdTick));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, exp, input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        // wait for ready; only the watchdog ends a hang
        do begin
            @(posedge clk_sys);
        end while (apbRsp.pready !== 1'b1);
        r = apbRsp.prdata;
        e = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x,
        input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk(e, xe, "slave error");
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_regs();
        rd(LBL_OFS_LADDER, LBL_RST_LADDER, 1'b0);
        rd(LBL_OFS_DISPLAY, LBL_RST_DISPLAY, 1'b0);
        rd(LBL_OFS_BIASREF, LBL_RST_BIASREF, 1'b0);
        rd(LBL_OFS_CONTRAST, LBL_RST_CONTRAST, 1'b0);
        rd(LBL_OFS_PINDIR, LBL_RST_PINDIR, 1'b0);
        wr(8'h18, 8'hFF);
        rd(8'h18, 32'h0, 1'b1);
        wr(LBL_OFS_LADDER, 8'hFF);
        rd(LBL_OFS_LADDER, 8'hF7, 1'b0);
        wr(LBL_OFS_BIASREF, 8'hFF);
        rd(LBL_OFS_BIASREF, 8'hEE, 1'b0);
        $display("test_regs done");
    endtask

    task automatic test_commons();
        logic [3:0] x;
        wr(LBL_OFS_PINDIR, 8'h05);
        for (int m = 0; m < 4; m++) begin
            wr(LBL_OFS_DISPLAY, m);
            settle();
            x = 4'((1 << (m + 1)) - 1);
            chk(comActive, x, "commons");
            chk(pinOe, x | 4'hA, "pin drive");
        end
        $display("test_commons done");
    endtask

    task automatic test_gating();
        wr(LBL_OFS_LADDER, 8'hF0);
        wr(LBL_OFS_DISPLAY, 8'h08);
        wr(LBL_OFS_BIASREF, 8'hEA);
        wr(LBL_OFS_CONTRAST, 8'h07);
        settle();
        chk(biasOut.ladderPower, 2'h0, "power idle");
        chk(biasOut.refEnable, 1'b0, "ref idle");
        chk(biasOut.contrastEnable, 1'b0, "contrast idle");
        chk(biasOut.biasPinConnect, 3'h5, "bias pins");
        @(posedge clk_sys);
        moduleActive <= 1'b1;
        settle();
        chk(biasOut.ladderPower, 2'h3, "power B");
        chk(biasOut.inIntervalA, 1'b0, "no A");
        chk(biasOut.shortMiddle, 1'b1, "half bias");
        chk(biasOut.contrastEnable, 1'b1, "contrast on");
        chk(biasOut.contrastTap, 3'h7, "contrast tap");
        chk(biasOut.fvrRequest, 1'b1, "fvr request");
        chk(biasOut.fvrBufferEnable, 1'b0, "buffer idle");
        rd(LBL_OFS_DISPLAY, 32'h0000_0088, 1'b0);
        rd(LBL_OFS_STATUS, 32'h0000_0B1F, 1'b0);
        wr(LBL_OFS_BIASREF, 8'hC0);
        settle();
        chk(biasOut.fvrBufferEnable, 1'b1, "buffer on");
        wr(LBL_OFS_BIASREF, 8'h00);
        wr(LBL_OFS_DISPLAY, 8'h00);
        settle();
        chk(biasOut.contrastEnable, 1'b0, "contrast no ref");
        chk(biasOut.fvrRequest, 1'b0, "fvr off");
        chk(biasOut.shortMiddle, 1'b0, "third bias");
        $display("test_gating done");
    endtask

    task automatic test_interval(input logic waveform_type, input logic [2:0] len,
        input logic [1:0] pa, input logic [1:0] pb);
        int period;
        logic inA;
        period = waveform_type ? 32 : 16;
        wr(LBL_OFS_DISPLAY, {waveform_type, 2'h0});
        wr(LBL_OFS_LADDER, {pa, pb, 1'b0, len});
        @(posedge clk_sys);
        tickRun <= 1'b0;
        lcdTransition <= 1'b1;
        @(posedge clk_sys);
        lcdTransition <= 1'b0;
        for (int k = 0; k <= period; k++) begin
            if (k == 1) begin
                @(posedge clk_sys);
                tickRun <= 1'b1;
            end
            if (k > 0) begin
                do @(posedge clk_sys); while (lcdTick !== 1'b1);
            end
            repeat (2) @(posedge clk_sys);
            #1;
            inA = (k % period) < len;
            chk(biasOut.inIntervalA, inA, "phase");
            chk(biasOut.ladderPower, inA ? pa : pb, "power");
        end
        $display("test_interval done");
    endtask

    task automatic test_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(biasOut, 32'h0, "outputs in reset");
        chk({comActive, pinOe}, 32'h0, "pins in reset");
        @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(LBL_OFS_LADDER, LBL_RST_LADDER, 1'b0);
        rd(LBL_OFS_CONTRAST, LBL_RST_CONTRAST, 1'b0);
        rd(LBL_OFS_PINDIR, LBL_RST_PINDIR, 1'b0);
        chk(comActive, 4'h1, "commons after reset");
        chk(pinOe, 4'h1, "pins after reset");
        $display("test_reset done");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        test_regs();
        test_commons();
        test_gating();
        test_interval(1'b0, 3'h1, 2'h3, 2'h1);
        test_interval(1'b0, 3'h7, 2'h1, 2'h2);
        test_interval(1'b0, 3'h0, 2'h2, 2'h3);
        test_interval(1'b1, 3'h1, 2'h0, 2'h3);
        test_interval(1'b1, 3'h7, 2'h2, 2'h0);
        test_reset();
        @(posedge clk_sys);
        moduleActive <= 1'b0;
        settle();
        chk(biasOut.ladderPower, 2'h0, "power off");
        conclude();
    end

    initial begin
        #(8 * 20000);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule // lbl_ladder_tb

// File: tb/lbl_lcd_tick_model.sv
// Purpose: lcd timing source giving the 32 khz tick pulses
// Assumes: one tick every four system clocks while running
// Notes: stops dead and restarts its count when run is low
`timescale 1ns/10ps
module lbl_lcd_tick_model (
    // clock
    input wire logic clk_sys,
    // control
    input wire logic run,
    // timing
    output logic lcdTick
);
    logic [1:0] phaseCnt = 2'h0;
    initial lcdTick = 1'b0;
    always @(posedge clk_sys) begin
        phaseCnt <= run ? phaseCnt + 2'h1 : 2'h0;
        lcdTick <= run && phaseCnt == 2'h3;
    end
endmodule // lbl_lcd_tick_model
